// ==== table_consts.vh ====
// Constants for the lookup-table store: commands, address map, tags and field positions
`ifndef TABLE_CONSTS_VH
`define TABLE_CONSTS_VH
`define CMD_TABLE_POINTER 8'h7A
`define CMD_TABLE_DATA_WR 8'h7B
`define CMD_TABLE_DATA_RD 8'hFB
`define TABLE_WORDS 6'h30
`define TEMP1_FIRST 8'h00
`define TEMP2_FIRST 8'h30
`define NUM1_FIRST 8'h60
`define NUM2_FIRST 8'h90
`define CONFIG_FIRST 8'hC0
`define BASE_FIRST 8'hC4
`define MEM_TOP 8'hC7
`define MEM_DEPTH 200
`define PTR_COUNT_MSB 15
`define PTR_COUNT_LSB 8
`define PTR_ADDR_MSB 7
`define PTR_ADDR_LSB 0
`define DATA_TAG 3'h6
`define EMPTY_TAG 4'hF
`define TAG_MSB 15
`define TAG_LSB 13
`define FIFO_WIDTH 16
`define FIFO_DEPTH 8
`define FIFO_AW 3
`define FLAG_BITS 12
`define STORE_MSB 12
`define CFG_SIZE_MSB 12
`define CFG_SIZE_LSB 7
`define CFG_HYS_MSB 6
`define CFG_HYS_LSB 4
`define CFG_STEP_MSB 3
`define CFG_STEP_LSB 0
`endif

// ==== word_fifo.v ====
// Word FIFO with valid/ready on both sides
module word_fifo #(
	parameter WIDTH = 16,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	input wire core_clk_in,
	input wire rst_in,
	input wire [WIDTH-1:0] wr_data_in,
	input wire wr_valid_in,
	output wire wr_ready_out,
	output wire [WIDTH-1:0] rd_data_out,
	output wire rd_valid_out,
	input wire rd_ready_in
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_reg;
	reg [AW-1:0] rd_ptr_reg;
	reg [AW:0] count_reg;
	wire push;
	wire pop;
	localparam integer LAST = DEPTH - 1;

	assign wr_ready_out = (count_reg != DEPTH[AW:0]);
	assign rd_valid_out = (count_reg != {(AW+1){1'b0}});
	assign rd_data_out = mem[rd_ptr_reg];
	assign push = wr_valid_in && wr_ready_out;
	assign pop = rd_valid_out && rd_ready_in;

	always @(posedge core_clk_in) begin
		if (push) begin
			mem[wr_ptr_reg] <= wr_data_in;
		end
	end

	always @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			wr_ptr_reg <= {AW{1'b0}};
			rd_ptr_reg <= {AW{1'b0}};
			count_reg <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr_reg <= (wr_ptr_reg == LAST[AW-1:0]) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == LAST[AW-1:0]) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
			end
			if (push && !pop) begin
				count_reg <= count_reg + 1'b1;
			end else if (pop && !push) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end
endmodule // word_fifo

// ==== lookup_table_access.v ====
// Lookup-table store: pointer, auto-increment writes, counted streaming reads into the output FIFO
`include "table_consts.vh"

// Overview of operation
// - Four tables of 48 words each
// - Table entries at 00h to BFh, four blocks
// - Configuration words at C0h to C3h
// - Base words at C4h to C7h
// - Command 7Ah loads the 16-bit pointer
// - Pointer: count high byte, address low byte
// - Writes ignore the count field
// - Data writes store then increment address
// - One read command streams words into FIFO
// - Streaming stops at count or memory top
// - FIFO words are 16 bits with tag
// - Each table holds base, step, hysteresis, size
// - Read words carry tag 110 on top
// - Full FIFO pauses copying until read
// - Empty read returns tag 1111 and flags
module lookup_table_access (
	input wire core_clk_in,
	input wire rst_in,
	input wire cmd_valid_in,
	input wire [7:0] cmd_byte_in,
	input wire [15:0] cmd_data_in,
	input wire fifo_read_in,
	input wire [11:0] flags_in,
	output reg [15:0] read_word_out,
	output reg read_word_valid_out,
	output reg copy_busy_out,
	output reg [15:0] table_pointer_out,
	output reg [5:0] config_size_out,
	output reg [2:0] config_hys_out,
	output reg [3:0] config_step_out
);
	localparam ST_IDLE = 1'b0;
	localparam ST_COPY = 1'b1;

	// Memory covers table entries, configuration and base words in one array
	reg [`STORE_MSB:0] mem [0:`MEM_DEPTH-1];
	reg [15:0] table_pointer_reg;
	reg [7:0] addr_reg;
	reg [7:0] remain_reg;
	reg state_reg;
	reg [`FLAG_BITS-1:0] flags_sync1_reg;
	reg [`FLAG_BITS-1:0] flags_sync2_reg;
	reg cmd_take_reg;
	reg [7:0] cmd_byte_reg;
	reg [15:0] cmd_data_reg;
	reg [`STORE_MSB:0] config_word_reg;
	reg [15:0] fill_word;
	reg fill_valid;
	wire fill_ready;
	wire [15:0] fifo_word;
	wire fifo_valid;
	wire pop;
	wire write_hit;
	genvar gi;

	// Address lies inside the table/config/base store
	function in_store;
		input [7:0] a;
		begin
			in_store = (a <= `MEM_TOP);
		end
	endfunction

	// Host-side strobes come from logic on this clock and are only registered once
	always @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			cmd_take_reg <= 1'b0;
			cmd_byte_reg <= 8'h00;
			cmd_data_reg <= 16'h0000;
		end else begin
			cmd_take_reg <= cmd_valid_in;
			cmd_byte_reg <= cmd_byte_in;
			cmd_data_reg <= cmd_data_in;
		end
	end

	// Flags come from another domain; bits may settle a cycle apart, harmless for status bits
	generate
		for (gi = 0; gi < `FLAG_BITS; gi = gi + 1) begin : g_flag_sync
			always @(posedge core_clk_in or posedge rst_in) begin
				if (rst_in) begin
					flags_sync1_reg[gi] <= 1'b0;
					flags_sync2_reg[gi] <= 1'b0;
				end else begin
					flags_sync1_reg[gi] <= flags_in[gi];
					flags_sync2_reg[gi] <= flags_sync1_reg[gi];
				end
			end
		end
	endgenerate

	// Writes are dropped while streaming so a copy never reads a half-written table
	assign write_hit = cmd_take_reg && (cmd_byte_reg == `CMD_TABLE_DATA_WR) && (state_reg == ST_IDLE) &&
		in_store(addr_reg);

	always @* begin
		fill_word = 16'h0000;
		fill_valid = (state_reg == ST_COPY) && in_store(addr_reg) && (remain_reg != 8'h00);
		if (in_store(addr_reg)) begin
			fill_word = {`DATA_TAG, mem[addr_reg]};
		end
	end

	always @(posedge core_clk_in) begin
		if (write_hit) begin
			mem[addr_reg] <= cmd_data_reg[`STORE_MSB:0];
		end
	end

	// Shadow of the first configuration word, so its fields leave reset at zero
	always @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			config_word_reg <= 13'h0;
		end else if (write_hit && (addr_reg == `CONFIG_FIRST)) begin
			config_word_reg <= cmd_data_reg[`STORE_MSB:0];
		end
	end

	always @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			table_pointer_reg <= 16'h0000;
			addr_reg <= 8'h00;
			remain_reg <= 8'h00;
			state_reg <= ST_IDLE;
		end else begin
			case (state_reg)
			ST_IDLE: begin
				if (cmd_take_reg) begin
					case (cmd_byte_reg)
					`CMD_TABLE_POINTER: begin
						table_pointer_reg <= cmd_data_reg;
						addr_reg <= cmd_data_reg[`PTR_ADDR_MSB:`PTR_ADDR_LSB];
					end
					`CMD_TABLE_DATA_WR: begin
						// Count field plays no part here; address only advances
						if (write_hit) begin
							addr_reg <= addr_reg + 8'h01;
						end
					end
					`CMD_TABLE_DATA_RD: begin
						addr_reg <= table_pointer_reg[`PTR_ADDR_MSB:`PTR_ADDR_LSB];
						remain_reg <= table_pointer_reg[`PTR_COUNT_MSB:`PTR_COUNT_LSB];
						state_reg <= ST_COPY;
					end
					default: begin
						state_reg <= ST_IDLE;
					end
					endcase
				end
			end
			ST_COPY: begin
				if (!fill_valid) begin
					state_reg <= ST_IDLE;
				end else if (fill_ready) begin
					// Stall while full; resumes once the host drains a word
					addr_reg <= addr_reg + 8'h01;
					remain_reg <= remain_reg - 8'h01;
				end
			end
			default: begin
				state_reg <= ST_IDLE;
			end
			endcase
		end
	end

	// Host reads go straight to the FIFO; an empty read still answers
	assign pop = fifo_read_in;

	word_fifo #(
		.WIDTH(`FIFO_WIDTH),
		.DEPTH(`FIFO_DEPTH),
		.AW(`FIFO_AW)
	) word_fifo_inst (
		.core_clk_in(core_clk_in),
		.rst_in(rst_in),
		.wr_data_in(fill_word),
		.wr_valid_in(fill_valid),
		.wr_ready_out(fill_ready),
		.rd_data_out(fifo_word),
		.rd_valid_out(fifo_valid),
		.rd_ready_in(pop)
	);

	// Read answer: one word per host read, or the empty marker with the flags
	always @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			read_word_out <= 16'h0000;
			read_word_valid_out <= 1'b0;
		end else begin
			read_word_valid_out <= pop;
			if (pop) begin
				read_word_out <= fifo_valid ? fifo_word : {`EMPTY_TAG, flags_sync2_reg};
			end
		end
	end

	// Status mirrors lag the internal state by one cycle
	always @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			copy_busy_out <= 1'b0;
			table_pointer_out <= 16'h0000;
		end else begin
			copy_busy_out <= (state_reg == ST_COPY);
			table_pointer_out <= table_pointer_reg;
		end
	end

	// Only the first configuration word is shown on the pins
	always @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			config_size_out <= 6'h00;
			config_hys_out <= 3'h0;
			config_step_out <= 4'h0;
		end else begin
			config_size_out <= config_word_reg[`CFG_SIZE_MSB:`CFG_SIZE_LSB];
			config_hys_out <= config_word_reg[`CFG_HYS_MSB:`CFG_HYS_LSB];
			config_step_out <= config_word_reg[`CFG_STEP_MSB:`CFG_STEP_LSB];
		end
	end
endmodule // lookup_table_access

// ==== host_model.sv ====
// Host controller model issuing commands and FIFO reads
module host_model (
	input wire core_clk_in,
	output logic cmd_valid_out = 1'b0,
	output logic fifo_read_out = 1'b0,
	output logic [7:0] cmd_byte_out = 8'h00,
	output logic [15:0] cmd_data_out = 16'h0000
);
	timeunit 1ns;
	timeprecision 1ps;
	// Released data is inverted so a stale word never passes
	task automatic send(logic [7:0] b, logic [15:0] v, logic r);
		@(posedge core_clk_in);
		#2;
		cmd_valid_out = !r;
		fifo_read_out = r;
		cmd_byte_out = b;
		cmd_data_out = v;
		@(posedge core_clk_in);
		#2;
		cmd_valid_out = 1'b0;
		fifo_read_out = 1'b0;
		cmd_data_out = ~v;
	endtask
endmodule // host_model

// ==== lookup_table_access_chk.sv ====
// Port checker for the lookup-table store
module lookup_table_access_chk (
	input wire core_clk_in,
	input wire rst_in,
	input wire cmd_valid_in,
	input wire fifo_read_in,
	input wire read_word_valid_out,
	input wire copy_busy_out,
	input wire [7:0] cmd_byte_in,
	input wire [11:0] flags_in,
	input wire [15:0] cmd_data_in,
	input wire [15:0] read_word_out,
	input wire [15:0] table_pointer_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge core_clk_in);
	endclocking
	default disable iff (rst_in);
	sequence s_ans;
		##1 read_word_valid_out;
	endsequence
	property p_rd; fifo_read_in |-> s_ans; endproperty
	a_rd: assert property (p_rd) else $error("no answer");
	property p_nrd; !fifo_read_in |=> !read_word_valid_out; endproperty
	a_nrd: assert property (p_nrd) else $error("stray word");
	property p_hold; !read_word_valid_out |-> $stable(read_word_out); endproperty
	a_hold: assert property (p_hold) else $error("word moved");
	property p_tag; read_word_valid_out |-> read_word_out[15:13] == 3'h6 || read_word_out[15:12] == 4'hF; endproperty
	a_tag: assert property (p_tag) else $error("bad tag");
	property p_empty; read_word_valid_out && read_word_out[15:12] == 4'hF |-> read_word_out[11:0] == flags_in;
	endproperty
	a_empty: assert property (p_empty) else $error("bad flags");
	property p_ptr;
		cmd_valid_in && cmd_byte_in == 8'h7A |-> ##3 table_pointer_out == $past(cmd_data_in, 3);
	endproperty
	a_ptr: assert property (p_ptr) else $error("pointer");
	property p_busy; cmd_valid_in && cmd_byte_in == 8'hFB && !copy_busy_out |-> ##[1:4] copy_busy_out; endproperty
	a_busy: assert property (p_busy) else $error("no copy");
	property p_keep; !cmd_valid_in [*3] |=> $stable(table_pointer_out); endproperty
	a_keep: assert property (p_keep) else $error("pointer moved");
endmodule // lookup_table_access_chk
bind lookup_table_access lookup_table_access_chk lookup_table_access_chk_inst (
	.core_clk_in(core_clk_in),
	.rst_in(rst_in),
	.cmd_valid_in(cmd_valid_in),
	.fifo_read_in(fifo_read_in),
	.read_word_valid_out(read_word_valid_out),
	.copy_busy_out(copy_busy_out),
	.cmd_byte_in(cmd_byte_in),
	.flags_in(flags_in),
	.cmd_data_in(cmd_data_in),
	.read_word_out(read_word_out),
	.table_pointer_out(table_pointer_out)
);

// ==== test_lookup_table_access.sv ====
// Self-checking bench for the lookup-table store
module test_lookup_table_access;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk_in = 0, rst_in = 1;
	logic [11:0] flags_in = 12'h000;
	logic [15:0] d, exp_q[$], mem[256];
	int err_count = 0, cmp_count = 0;
	wire cmd_valid_in, fifo_read_in, read_word_valid_out, copy_busy_out;
	wire [2:0] config_hys_out;
	wire [3:0] config_step_out;
	wire [5:0] config_size_out;
	wire [7:0] cmd_byte_in;
	wire [15:0] cmd_data_in, read_word_out, table_pointer_out;
	always #12.5 core_clk_in = ~core_clk_in;
	lookup_table_access lookup_table_access_inst (
		.core_clk_in(core_clk_in),
		.rst_in(rst_in),
		.cmd_valid_in(cmd_valid_in),
		.cmd_byte_in(cmd_byte_in),
		.cmd_data_in(cmd_data_in),
		.fifo_read_in(fifo_read_in),
		.flags_in(flags_in),
		.read_word_out(read_word_out),
		.read_word_valid_out(read_word_valid_out),
		.copy_busy_out(copy_busy_out),
		.table_pointer_out(table_pointer_out),
		.config_size_out(config_size_out),
		.config_hys_out(config_hys_out),
		.config_step_out(config_step_out)
	);
	host_model host_model_inst (
		.core_clk_in(core_clk_in),
		.cmd_valid_out(cmd_valid_in),
		.fifo_read_out(fifo_read_in),
		.cmd_byte_out(cmd_byte_in),
		.cmd_data_out(cmd_data_in)
	);
	task automatic chk(string n, logic [15:0] s, e);
		cmp_count++;
		if (s !== e) begin
			err_count++;
			$display("[FAIL] %s exp %h seen %h", n, e, s);
		end
	endtask
	task automatic stop_test;
		$display("%0d errors in %0d checks", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Count field set on writes too; more than eight words stalls the copy
	task automatic run(int a, n, w, k);
		host_model_inst.send(8'h7A, {n[7:0], a[7:0]}, 0);
		for (int i = 0; i < w; i++) begin
			d = 16'($urandom);
			host_model_inst.send(8'h7B, d, 0);
			mem[a + i] = d;
		end
		host_model_inst.send(8'h7A, {n[7:0], a[7:0]}, 0);
		host_model_inst.send(8'hFB, d, 0);
		repeat (20) @(negedge core_clk_in);
		chk("busy", {15'h0, copy_busy_out}, {15'h0, k > 8});
		chk("pointer", table_pointer_out, {n[7:0], a[7:0]});
		for (int i = 0; i <= k; i++) begin
			exp_q.push_back(i < k ? {3'h6, mem[a + i][12:0]} : {4'hF, flags_in});
			host_model_inst.send(8'h00, d, 1);
			repeat (2) @(posedge core_clk_in);
		end
	endtask
	always @(negedge core_clk_in)
		if (read_word_valid_out === 1'b1)
			chk("word", read_word_out, exp_q.pop_front());
	initial begin
		#100000;
		err_count++;
		stop_test;
	end
	initial begin
		d = 16'($urandom(32'hDFF7));
		flags_in = 12'($urandom);
		repeat (12) @(posedge core_clk_in);
		#2;
		rst_in = 0;
		run(8'hC0, 1, 1, 1);
		chk("size", {10'h000, config_size_out}, {10'h000, mem[8'hC0][12:7]});
		chk("hyst", {13'h0, config_hys_out}, {13'h0, mem[8'hC0][6:4]});
		chk("step", {12'h000, config_step_out}, {12'h000, mem[8'hC0][3:0]});
		run(8'h2E, 10, 10, 10);
		run(8'hC5, 48, 4, 3);
		chk("pending", 16'(exp_q.size()), 16'h0000);
		stop_test;
	end
endmodule // test_lookup_table_access
